// ### rtl/ifm_ctrl.sv
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "ifm_regs.svh"

module ifm_ctrl #(
    parameter int ADDR_W = 8
) (
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic [ADDR_W-1:0]      avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   ext_irq_pin_a,
    input  wire logic                   ext_irq_pin_b,
    input  wire ifm_pkg::ifm_core_in_t   core_in,
    input  wire ifm_pkg::ifm_timer_evt_t timer_evt,
    output ifm_pkg::ifm_core_out_t       core_out
);
    import ifm_pkg::*;

    // ***********************************
    // elaboration check
    // ***********************************
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ifm_ctrl: ADDR_W must be at least 6");
    end

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        logic [7:0] mcu_ctrl;
        logic [7:0] ext_mask;
        logic [7:0] ext_flags;
        logic [7:0] tmr_mask;
        logic [7:0] tmr_flags;
        logic       global_en;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic       pin_a;
        logic       pin_b;
        ifm_seq_t   seq;
        logic [2:0] cnt;
        logic [2:0] src;
        logic [3:0] vec_addr;
        logic       vec_load;
        logic       post_ret;
        logic       sleeping;
        logic       ack;
        logic [7:0] rdata;
    } ifm_state_t;

    ifm_state_t state_reg;
    ifm_state_t state_next;

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic edge_hit(input logic [1:0] mode, input logic chg, input logic lvl);
        case (mode)
            `IFM_SENSE_ANY:  edge_hit = chg;
            `IFM_SENSE_FALL: edge_hit = chg & ~lvl;
            `IFM_SENSE_RISE: edge_hit = chg & lvl;
            default:         edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // lowest index is lowest vector address
    function automatic logic [2:0] pick_src(input logic [`IFM_NUM_SRC-1:0] req);
        pick_src = `IFM_NO_SRC;
        for (int i = `IFM_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick_src = i[2:0];
            end
        end
    endfunction : pick_src

    function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] addr);
        idx_of = 8'(addr);
    endfunction : idx_of

    // ***********************************
    // combinational next state
    // ***********************************
    logic [1:0]             sense_a;
    logic [1:0]             sense_b;
    logic                   stable_a;
    logic                   stable_b;
    logic                   evt_a;
    logic                   evt_b;
    logic                   lvl_a;
    logic                   lvl_b;
    logic [`IFM_NUM_SRC-1:0] req;
    logic [`IFM_NUM_SRC-1:0] masked;
    logic                   wr_ok;
    logic [7:0]             widx;
    logic [7:0]             wd;
    logic                   wide_ovf_set;

    always_comb begin
        state_next = state_reg;
        state_next.vec_load = 1'b0;

        sense_a = {state_reg.mcu_ctrl[`IFM_FLD_SENSE_A_HI], state_reg.mcu_ctrl[`IFM_FLD_SENSE_A_LO]};
        sense_b = {state_reg.mcu_ctrl[`IFM_FLD_SENSE_B_HI], state_reg.mcu_ctrl[`IFM_FLD_SENSE_B_LO]};

        // pad level is used whatever the pin direction, so a driven pin can raise a request
        state_next.sync_a = {state_reg.sync_a[1:0], ext_irq_pin_a};
        state_next.sync_b = {state_reg.sync_b[1:0], ext_irq_pin_b};
        stable_a = (state_reg.sync_a[1] == state_reg.sync_a[2]);
        stable_b = (state_reg.sync_b[1] == state_reg.sync_b[2]);
        if (stable_a) begin
            state_next.pin_a = state_reg.sync_a[2];
        end
        if (stable_b) begin
            state_next.pin_b = state_reg.sync_b[2];
        end
        evt_a = edge_hit(sense_a, stable_a && (state_reg.sync_a[2] != state_reg.pin_a), state_reg.sync_a[2]);
        evt_b = edge_hit(sense_b, stable_b && (state_reg.sync_b[2] != state_reg.pin_b), state_reg.sync_b[2]);
        // level mode has no flag; request lives only while the pin is low
        lvl_a = (sense_a == `IFM_SENSE_LOW) && !state_reg.pin_a;
        lvl_b = (sense_b == `IFM_SENSE_LOW) && !state_reg.pin_b;

        // ***********************************
        // bus slave: one wait cycle, then answer
        // ***********************************
        state_next.ack = (avs_read || avs_write) && !state_reg.ack;
        wr_ok = avs_write && state_reg.ack;
        widx  = idx_of(avs_address);
        wd    = avs_writedata[7:0];
        if ((avs_read || avs_write) && !state_reg.ack) begin
            case (idx_of(avs_address))
                `IFM_IDX_MCU_CTRL:    state_next.rdata = state_reg.mcu_ctrl;
                `IFM_IDX_TMR_FLAGS:   state_next.rdata = state_reg.tmr_flags;
                `IFM_IDX_TMR_MASK:    state_next.rdata = state_reg.tmr_mask;
                `IFM_IDX_EXT_FLAGS:   state_next.rdata = state_reg.ext_flags;
                `IFM_IDX_EXT_MASK:    state_next.rdata = state_reg.ext_mask;
                `IFM_IDX_CORE_STATUS: state_next.rdata = {state_reg.global_en, 7'h00};
                default:              state_next.rdata = `IFM_RST_VAL;
            endcase
        end
        if (wr_ok) begin
            case (widx)
                `IFM_IDX_MCU_CTRL:    state_next.mcu_ctrl  = wd & `IFM_MCU_RW_BITS;
                `IFM_IDX_TMR_MASK:    state_next.tmr_mask  = wd & `IFM_TMR_BITS;
                `IFM_IDX_EXT_MASK:    state_next.ext_mask  = wd & `IFM_EXT_BITS;
                `IFM_IDX_TMR_FLAGS:   state_next.tmr_flags = state_reg.tmr_flags & ~wd;
                `IFM_IDX_EXT_FLAGS:   state_next.ext_flags = state_reg.ext_flags & ~wd;
                `IFM_IDX_CORE_STATUS: state_next.global_en = wd[`IFM_BIT_GLOBAL_EN];
                default:              ;
            endcase
        end

        // ***********************************
        // sources, lowest vector first
        // ***********************************
        req[0] = state_reg.ext_flags[`IFM_BIT_EXT_A] || lvl_a;
        req[1] = state_reg.ext_flags[`IFM_BIT_EXT_B] || lvl_b;
        req[2] = state_reg.tmr_flags[`IFM_BIT_WIDE_CAP];
        req[3] = state_reg.tmr_flags[`IFM_BIT_WIDE_MATCH];
        req[4] = state_reg.tmr_flags[`IFM_BIT_WIDE_OVF];
        req[5] = state_reg.tmr_flags[`IFM_BIT_NARROW_OVF];
        masked[0] = req[0] && state_reg.ext_mask[`IFM_BIT_EXT_A];
        masked[1] = req[1] && state_reg.ext_mask[`IFM_BIT_EXT_B];
        masked[2] = req[2] && state_reg.tmr_mask[`IFM_BIT_WIDE_CAP];
        masked[3] = req[3] && state_reg.tmr_mask[`IFM_BIT_WIDE_MATCH];
        masked[4] = req[4] && state_reg.tmr_mask[`IFM_BIT_WIDE_OVF];
        masked[5] = req[5] && state_reg.tmr_mask[`IFM_BIT_NARROW_OVF];

        // ***********************************
        // sequencer
        // ***********************************
        case (state_reg.seq)
            IFM_IDLE: begin
                if (core_in.return_from_irq_op) begin
                    state_next.seq = IFM_RETURN;
                    state_next.cnt = 3'h0;
                end else if (core_in.insn_done && state_reg.post_ret) begin
                    state_next.post_ret = 1'b0;
                end else if (core_in.insn_done && state_reg.global_en && (masked != '0)) begin
                    state_next.seq       = IFM_ENTRY;
                    state_next.cnt       = 3'h0;
                    state_next.src       = pick_src(masked);
                    state_next.vec_addr  = 4'(pick_src(masked)) + 4'h1;
                    state_next.global_en = 1'b0;
                end
            end
            IFM_ENTRY: begin
                if (state_reg.cnt == `IFM_ENTRY_CYCLES - 3'h1) begin
                    state_next.seq      = IFM_JUMP;
                    state_next.cnt      = 3'h0;
                    state_next.vec_load = 1'b1;
                    case (state_reg.src)
                        3'h0:    state_next.ext_flags[`IFM_BIT_EXT_A]      = 1'b0;
                        3'h1:    state_next.ext_flags[`IFM_BIT_EXT_B]      = 1'b0;
                        3'h2:    state_next.tmr_flags[`IFM_BIT_WIDE_CAP]   = 1'b0;
                        3'h3:    state_next.tmr_flags[`IFM_BIT_WIDE_MATCH] = 1'b0;
                        3'h4:    state_next.tmr_flags[`IFM_BIT_WIDE_OVF]   = 1'b0;
                        3'h5:    state_next.tmr_flags[`IFM_BIT_NARROW_OVF] = 1'b0;
                        default: ;
                    endcase
                end else begin
                    state_next.cnt = state_reg.cnt + 3'h1;
                end
            end
            IFM_JUMP: begin
                if (state_reg.cnt == `IFM_JUMP_CYCLES - 3'h1) begin
                    state_next.seq = IFM_IDLE;
                end else begin
                    state_next.cnt = state_reg.cnt + 3'h1;
                end
            end
            IFM_RETURN: begin
                if (state_reg.cnt == `IFM_RETURN_CYCLES - 3'h1) begin
                    state_next.seq       = IFM_IDLE;
                    state_next.global_en = 1'b1;
                    state_next.post_ret  = 1'b1;
                end else begin
                    state_next.cnt = state_reg.cnt + 3'h1;
                end
            end
            default: begin
                state_next.seq = IFM_IDLE;
            end
        endcase

        // ***********************************
        // flag sets last: a set beats a same-cycle clear
        // ***********************************
        wide_ovf_set = timer_evt.wide_pwm_mode ? timer_evt.wide_zero_advance : timer_evt.wide_ovf;
        if (evt_a) begin
            state_next.ext_flags[`IFM_BIT_EXT_A] = 1'b1;
        end
        if (evt_b) begin
            state_next.ext_flags[`IFM_BIT_EXT_B] = 1'b1;
        end
        if (wide_ovf_set) begin
            state_next.tmr_flags[`IFM_BIT_WIDE_OVF] = 1'b1;
        end
        if (timer_evt.wide_match) begin
            state_next.tmr_flags[`IFM_BIT_WIDE_MATCH] = 1'b1;
        end
        if (timer_evt.wide_capture_done) begin
            state_next.tmr_flags[`IFM_BIT_WIDE_CAP] = 1'b1;
        end
        if (timer_evt.narrow_ovf) begin
            state_next.tmr_flags[`IFM_BIT_NARROW_OVF] = 1'b1;
        end

        // ***********************************
        // sleep: any enabled request wakes, even with global enable off
        // ***********************************
        if (core_in.sleep_op && state_reg.mcu_ctrl[`IFM_BIT_SLEEP_ALLOW]) begin
            state_next.sleeping = 1'b1;
        end else if (masked != '0) begin
            state_next.sleeping = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg          <= '0;
            state_reg.sync_a   <= 3'h7;
            state_reg.sync_b   <= 3'h7;
            state_reg.pin_a    <= 1'b1;
            state_reg.pin_b    <= 1'b1;
            state_reg.seq      <= IFM_IDLE;
            state_reg.src      <= `IFM_NO_SRC;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
    assign avs_readdata    = {24'h000000, state_reg.rdata};

    always_comb begin
        core_out.push_pc          = (state_reg.seq == IFM_ENTRY);
        core_out.pop_pc           = (state_reg.seq == IFM_RETURN);
        core_out.vector_load      = state_reg.vec_load;
        core_out.vector_addr      = state_reg.vec_addr;
        core_out.sleeping         = state_reg.sleeping;
        core_out.sleep_power_down = state_reg.mcu_ctrl[`IFM_BIT_SLEEP_TYPE];
    end

endmodule : ifm_ctrl

// ### rtl/ifm_regs.svh
`ifndef IFM_REGS_SVH
`define IFM_REGS_SVH

// ***********************************
// register indices (byte address = 4 * index)
// ***********************************
`define IFM_IDX_MCU_CTRL     8'h35
`define IFM_IDX_TMR_FLAGS    8'h38
`define IFM_IDX_TMR_MASK     8'h39
`define IFM_IDX_EXT_FLAGS    8'h3A
`define IFM_IDX_EXT_MASK     8'h3B
`define IFM_IDX_CORE_STATUS  8'h3F

// ***********************************
// reset values and writable bits
// ***********************************
`define IFM_RST_VAL          8'h00
`define IFM_MCU_RW_BITS      8'h3F
`define IFM_EXT_BITS         8'hC0
`define IFM_TMR_BITS         8'hCA

// ***********************************
// field positions
// ***********************************
`define IFM_BIT_EXT_B        7
`define IFM_BIT_EXT_A        6
`define IFM_BIT_WIDE_OVF     7
`define IFM_BIT_WIDE_MATCH   6
`define IFM_BIT_WIDE_CAP     3
`define IFM_BIT_NARROW_OVF   1
`define IFM_BIT_SLEEP_ALLOW  5
`define IFM_BIT_SLEEP_TYPE   4
`define IFM_FLD_SENSE_B_HI   3
`define IFM_FLD_SENSE_B_LO   2
`define IFM_FLD_SENSE_A_HI   1
`define IFM_FLD_SENSE_A_LO   0
`define IFM_BIT_GLOBAL_EN    7

// ***********************************
// sense encodings and cycle counts
// ***********************************
`define IFM_SENSE_LOW        2'h0
`define IFM_SENSE_ANY        2'h1
`define IFM_SENSE_FALL       2'h2
`define IFM_SENSE_RISE       2'h3
`define IFM_ENTRY_CYCLES     3'h4
`define IFM_JUMP_CYCLES      3'h2
`define IFM_RETURN_CYCLES    3'h4
`define IFM_NUM_SRC          6
`define IFM_NO_SRC           3'h7

`endif

// ### rtl/ifm_pkg.sv
package ifm_pkg;

    typedef enum logic [2:0] {
        IFM_IDLE   = 3'h0,
        IFM_ENTRY  = 3'h1,
        IFM_JUMP   = 3'h2,
        IFM_RETURN = 3'h3
    } ifm_seq_t;

    // pulses from the core sequencer
    typedef struct packed {
        logic insn_done;
        logic return_from_irq_op;
        logic sleep_op;
    } ifm_core_in_t;

    // one-cycle strobes from the timers, plus the wide timer's pwm mode level
    typedef struct packed {
        logic wide_ovf;
        logic wide_zero_advance;
        logic wide_pwm_mode;
        logic wide_match;
        logic wide_capture_done;
        logic narrow_ovf;
    } ifm_timer_evt_t;

    typedef struct packed {
        logic       push_pc;
        logic       pop_pc;
        logic       vector_load;
        logic [3:0] vector_addr;
        logic       sleeping;
        logic       sleep_power_down;
    } ifm_core_out_t;

endpackage : ifm_pkg

// ### tb/ifm_core_model.sv
`timescale 1ns/10ps
// ****************
// core and timer stand-in
// ****************
module ifm_core_model (
    input  wire logic               mclk,
    output ifm_pkg::ifm_core_in_t   core_in,
    output ifm_pkg::ifm_timer_evt_t timer_evt
);
    import ifm_pkg::*;
    logic run_en;
    logic phase;
    initial begin
        core_in = '0;
        timer_evt = '0;
        run_en = 1'b0;
        phase = 1'b0;
    end
    // an instruction ends every other cycle, so entry waits on completion
    always @(posedge mclk) begin
        phase <= ~phase;
        core_in.insn_done <= run_en & phase;
    end
    task run(input logic v);
        @(posedge mclk);
        run_en <= v;
    endtask : run
    // one-cycle strobes; the pwm level bit is never in the mask
    task pulse(input logic [5:0] m);
        @(posedge mclk);
        timer_evt <= timer_evt | m;
        @(posedge mclk);
        timer_evt <= timer_evt & ~m;
    endtask : pulse
    task pwm(input logic v);
        @(posedge mclk);
        timer_evt.wide_pwm_mode <= v;
    endtask : pwm
    // let the two jump cycles pass: a return during the jump is ignored
    task do_ret;
        repeat (2) @(posedge mclk);
        core_in.return_from_irq_op <= 1'b1;
        @(posedge mclk);
        core_in.return_from_irq_op <= 1'b0;
    endtask : do_ret
    task do_sleep;
        @(posedge mclk);
        core_in.sleep_op <= 1'b1;
        @(posedge mclk);
        core_in.sleep_op <= 1'b0;
    endtask : do_sleep
endmodule : ifm_core_model

// ### tb/ifm_ctrl_sva.sv
`timescale 1ns/10ps
// ****************
// checker
// ****************
module ifm_ctrl_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic                    mclk,
    input wire logic                    reset,
    input wire logic [ADDR_W-1:0]       avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_writedata,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    input wire logic                    ext_irq_pin_a,
    input wire logic                    ext_irq_pin_b,
    input wire ifm_pkg::ifm_core_in_t   core_in,
    input wire ifm_pkg::ifm_timer_evt_t timer_evt,
    input wire ifm_pkg::ifm_core_out_t  core_out
);
    import ifm_pkg::*;
    logic [7:0] ctl_reg;
    logic       post_ret_reg;
    // shadow of the control byte, taken at the completing edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl_reg <= 8'h00;
            post_ret_reg <= 1'b0;
        end else begin
            if (avs_write && !avs_waitrequest && avs_address == 8'h35) begin
                ctl_reg <= avs_writedata[7:0];
            end
            post_ret_reg <= core_out.pop_pc | (post_ret_reg & ~core_in.insn_done);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_push_len: assert property ($rose(core_out.push_pc) |-> core_out.push_pc [*4] ##1 !core_out.push_pc)
        else $error("push_pc not four cycles");
    a_entry_cause: assert property ($rose(core_out.push_pc) |-> $past(core_in.insn_done))
        else $error("entry without finished instruction");
    a_vec_follow: assert property ($fell(core_out.push_pc) |-> core_out.vector_load && core_out.vector_addr inside {[1:6]})
        else $error("vector missing after push");
    a_jump_gap: assert property (core_out.vector_load |=> !core_out.push_pc [*2])
        else $error("entry during jump");
    a_pop_len: assert property ($rose(core_out.pop_pc) |-> core_out.pop_pc [*4] ##1 !core_out.pop_pc)
        else $error("pop_pc not four cycles");
    a_post_ret: assert property ($rose(core_out.push_pc) |-> !$past(post_ret_reg))
        else $error("entry right after return");
    a_sleep_gate: assert property (core_in.sleep_op && !ctl_reg[5] && !core_out.sleeping |=> !core_out.sleeping)
        else $error("sleep without allow");
    a_sleep_type: assert property (core_out.sleep_power_down == ctl_reg[4])
        else $error("sleep type differs from control");
    a_resv_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    c_vec_a: cover property (core_out.vector_load && core_out.vector_addr == 4'h1);
    c_pop: cover property ($rose(core_out.pop_pc));
    c_sleep: cover property ($rose(core_out.sleeping));
endmodule : ifm_ctrl_sva

bind ifm_ctrl ifm_ctrl_sva #(.ADDR_W(ADDR_W)) i_ifm_ctrl_sva (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b), .core_in(core_in),
    .timer_evt(timer_evt), .core_out(core_out));

// ### tb/ifm_ctrl_tb.sv
`timescale 1ns/10ps
module ifm_ctrl_tb;
    import ifm_pkg::*;
    logic           mclk, reset, avs_read, avs_write, pin_a, pin_b, avs_waitrequest;
    logic [7:0]     avs_address, fm, q;
    logic [31:0]    avs_writedata, avs_readdata;
    ifm_core_in_t   core_in;
    ifm_timer_evt_t timer_evt;
    ifm_core_out_t  core_out;
    int             n_errors, checks_done;
    ifm_ctrl #(.ADDR_W(8)) i_ifm_ctrl (.mclk(mclk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .core_in(core_in),
        .timer_evt(timer_evt), .core_out(core_out));
    ifm_core_model i_ifm_core_model (.mclk(mclk), .core_in(core_in), .timer_evt(timer_evt));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ****************
    // tasks
    // ****************
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    // request held until the edge where waitrequest is seen low
    // upper data bits driven high: only the low byte may matter
    task bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'hFFFFFF, d};
        avs_write <= is_wr;
        avs_read <= ~is_wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) chk8(8'h00, 8'h01);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk8(q, e);
    endtask : rd
    task gap(input int n);
        repeat (n) @(posedge mclk);
    endtask : gap
    task pin(input int p, input logic v);
        @(posedge mclk);
        if (p == 1) pin_b <= v;
        else pin_a <= v;
    endtask : pin
    // bounded wait; a missing pulse shows as a mismatch on the top bit
    task wait_vec(input logic [3:0] v);
        int n;
        n = 0;
        @(negedge mclk);
        while (core_out.vector_load !== 1'b1 && n < 80) begin
            @(negedge mclk);
            n++;
        end
        chk8({core_out.vector_load, 3'h0, core_out.vector_addr}, {4'h8, v});
    endtask : wait_vec
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("BAD %0t watchdog", $time);
        stop_test();
    end
    // ****************
    // tests
    // ****************
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, n_errors, checks_done} = '0;
        {reset, pin_a, pin_b} = 3'h7;
        gap(10);
        reset <= 1'b0;
        for (int i = 0; i < 11; i++) rd(8'h35 + 8'(i), 8'h00);
        wr(8'h35, 8'hFF);
        rd(8'h35, 8'h3F);
        wr(8'h39, 8'hFF);
        rd(8'h39, 8'hCA);
        wr(8'h3B, 8'hFF);
        rd(8'h3B, 8'hC0);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(8'h35, 8'h00);
        wr(8'h39, 8'h00);
        wr(8'h3B, 8'h00);
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                fm = (p == 1) ? 8'h80 : 8'h40;
                wr(8'h35, (p == 1) ? 8'(m << 2) : 8'(m));
                wr(8'h3A, 8'hC0);
                pin(p, 1'b0);
                gap(8);
                rd(8'h3A, (m == 1 || m == 2) ? fm : 8'h00);
                wr(8'h3A, 8'hC0);
                pin(p, 1'b1);
                gap(8);
                rd(8'h3A, (m == 1 || m == 3) ? fm : 8'h00);
            end
        end
        $display("test sensing done");
        i_ifm_core_model.pwm(1'b1);
        i_ifm_core_model.pulse(6'h20);
        rd(8'h38, 8'h00);
        i_ifm_core_model.pulse(6'h10);
        rd(8'h38, 8'h80);
        wr(8'h38, 8'h80);
        i_ifm_core_model.pwm(1'b0);
        i_ifm_core_model.pulse(6'h10);
        rd(8'h38, 8'h00);
        $display("test pwm done");
        wr(8'h35, 8'h0A);
        pin(0, 1'b0);
        pin(1, 1'b0);
        gap(8);
        pin(0, 1'b1);
        pin(1, 1'b1);
        i_ifm_core_model.pulse(6'h27);
        gap(8);
        rd(8'h38, 8'hCA);
        rd(8'h3A, 8'hC0);
        wr(8'h39, 8'hCA);
        wr(8'h3B, 8'hC0);
        wr(8'h3F, 8'h80);
        i_ifm_core_model.run(1'b1);
        for (int v = 1; v < 7; v++) begin
            wait_vec(4'(v));
            rd(8'h3F, 8'h00);
            i_ifm_core_model.do_ret();
        end
        gap(8);
        rd(8'h3F, 8'h80);
        rd(8'h38, 8'h00);
        rd(8'h3A, 8'h00);
        $display("test vectors done");
        wr(8'h3B, 8'h00);
        wr(8'h35, 8'h00);
        wr(8'h3B, 8'h40);
        pin(0, 1'b0);
        wait_vec(4'h1);
        i_ifm_core_model.do_ret();
        wait_vec(4'h1);
        pin(0, 1'b1);
        i_ifm_core_model.do_ret();
        gap(12);
        rd(8'h3A, 8'h00);
        i_ifm_core_model.run(1'b0);
        $display("test level done");
        wr(8'h3B, 8'h00);
        wr(8'h39, 8'h00);
        wr(8'h35, 8'h10);
        i_ifm_core_model.do_sleep();
        gap(3);
        @(negedge mclk);
        chk8({6'h0, core_out.sleeping, core_out.sleep_power_down}, 8'h01);
        wr(8'h35, 8'h30);
        i_ifm_core_model.do_sleep();
        gap(3);
        @(negedge mclk);
        chk8({6'h0, core_out.sleeping, core_out.sleep_power_down}, 8'h03);
        wr(8'h39, 8'h02);
        i_ifm_core_model.pulse(6'h01);
        gap(3);
        @(negedge mclk);
        chk8({6'h0, core_out.sleeping, core_out.sleep_power_down}, 8'h01);
        $display("test sleep done");
        stop_test();
    end
endmodule : ifm_ctrl_tb
